// *** verilog/fpi_ctrl.sv ***
// front-panel status LED and bar-graph meter controller
// Notes on behaviour
// - power lamp green after good power-up, red while transmitting.
// - hardware error flashes all status lamps red at 1 Hz.
// - receive lamp dark without signal, red on carrier without sync.
// - receive lamp green when synced; each sync loss gives visible red.
// - port data lamp flashes red on input, green on output.
// - each button press in normal use toggles bar-graph display on or off.
// - bar-graph display turns itself off after 5 minutes on.
// - supply meter red 10-10.9 V, green 11-15.6 V, last red above.
// - power meter green from 20 dBm, last segment red at 40.7.
// - drive meter green from 10 dBm, last segment red at 26.0.
// - receive meter red -120 to -110.1 dBm, green from -110.
// - offset meter one lamp, red beyond 3.6 kHz, dark without signal.
// - offset meter holds its peak 5 seconds before following down.
// - button held at power-up runs a lamp test, then normal use.
`include "fpi_defs.svh"
`default_nettype none
module fpi_ctrl #(
	parameter int          SEG        = `FPI_SEG,
	parameter int unsigned TICK_CYC   = `FPI_TICK_CYC,
	parameter int unsigned DISP_TO_MS = `FPI_DISP_TO_MS,
	parameter int unsigned PEAK_MS    = `FPI_PEAK_MS
) (
	input  wire logic               ref_clk_i,
	input  wire logic               arst_n_i,
	input  wire logic               powerup_ok_i,
	input  wire logic               tx_active_i,
	input  wire logic               hw_error_i,
	input  wire logic               rx_carrier_i,
	input  wire logic               rx_sync_i,
	input  wire logic [1:0]         port_in_data_i,
	input  wire logic [1:0]         port_out_data_i,
	input  wire logic               disp_btn_i,
	input  wire logic [7:0]         supply_i,
	input  wire logic [8:0]         tx_power_i,
	input  wire logic [8:0]         tx_drive_i,
	input  wire logic signed [11:0] rx_sig_i,
	input  wire logic signed [7:0]  freq_off_i,
	output var  fpi_pkg::fpi_mode_t mode_o,
	output logic                    power_tx_indicator_red_o,
	output logic                    power_tx_indicator_green_o,
	output logic                    rx_sync_red_o,
	output logic                    rx_sync_green_o,
	output logic [1:0]              data_red_o,
	output logic [1:0]              data_green_o,
	output logic [SEG-1:0]          sup_red_o,
	output logic [SEG-1:0]          sup_green_o,
	output logic [SEG-1:0]          txp_red_o,
	output logic [SEG-1:0]          txp_green_o,
	output logic [SEG-1:0]          drv_red_o,
	output logic [SEG-1:0]          drv_green_o,
	output logic [SEG-1:0]          rxs_red_o,
	output logic [SEG-1:0]          rxs_green_o,
	output logic [SEG-1:0]          fo_red_o,
	output logic [SEG-1:0]          fo_green_o
);
	import fpi_pkg::*;
	localparam logic [SEG-1:0] ALL  = {SEG{1'b1}};
	localparam logic [SEG-1:0] LAST = {1'b1, {(SEG - 1){1'b0}}};
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// ****************************************************************
	// helpers
	// ****************************************************************
	// linear bar: one segment at lo, all segments just below hi
	function automatic logic [SEG-1:0] bar(input int v, input int lo,
		input int hi);
		int n;
		n = 0;
		if (v >= hi) begin
			n = SEG;
		end else if (v >= lo) begin
			n = ((v - lo) * SEG) / (hi - lo) + 1;
		end
		for (int i = 0; i < SEG; i++) begin
			bar[i] = (i < n);
		end
	endfunction
	function automatic logic [SEG-1:0] onehot(input int idx);
		for (int i = 0; i < SEG; i++) begin
			onehot[i] = (i == idx);
		end
	endfunction
	function automatic int mag(input logic signed [7:0] v);
		mag = (v < 0) ? -int'(v) : int'(v);
	endfunction
	// ****************************************************************
	// state
	// ****************************************************************
	fpi_mode_t   mode_reg, mode_next;
	logic [31:0] tick_cnt_reg, blink_cnt_reg, to_cnt_reg, hold_cnt_reg;
	logic [31:0] flick_cnt_reg, step_reg, step_cnt_reg;
	logic [31:0] din_cnt_reg [2];
	logic [31:0] dout_cnt_reg [2];
	logic        blink_reg, btn_prev_reg, sync_prev_reg, disp_on_reg;
	logic signed [7:0] peak_reg;
	wire tick     = (tick_cnt_reg == TICK_CYC - 1);
	wire btn_rise = disp_btn_i && !btn_prev_reg && (mode_reg == FPI_RUN);
	wire sync_drop = sync_prev_reg && !rx_sync_i && rx_carrier_i;
	wire flick_on = (flick_cnt_reg != 32'h0);
	wire to_hit   = disp_on_reg && (to_cnt_reg >= DISP_TO_MS);
	wire peak_new = (mag(freq_off_i) >= mag(peak_reg));
	wire hold_end = (hold_cnt_reg >= PEAK_MS);
	wire step_end = (step_cnt_reg == `FPI_TEST_MS - 1) && tick;
	// strap capture: the button level is judged on the first edge after
	// reset release, never under the reset itself
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			FPI_INIT: mode_next = disp_btn_i ? FPI_TEST : FPI_RUN;
			FPI_TEST: if (step_end && step_reg == 2 * SEG - 1) begin
				mode_next = FPI_RUN;
			end
			FPI_RUN:  mode_next = FPI_RUN;
			default:  mode_next = FPI_INIT;
		endcase
	end

	// ms tick and 1 Hz blink phase
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt_reg  <= 32'h0;
			blink_cnt_reg <= 32'h0;
			blink_reg     <= 1'b0;
		end else begin
			tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
			if (tick) begin
				blink_cnt_reg <= (blink_cnt_reg == `FPI_BLINK_MS - 1) ?
					32'h0 : blink_cnt_reg + 32'h1;
				if (blink_cnt_reg == `FPI_BLINK_MS - 1) begin
					blink_reg <= !blink_reg;
				end
			end
		end
	end

	// mode, lamp-test stepping and display on/off with timeout
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg     <= FPI_INIT;
			mode_o       <= FPI_INIT;
			step_reg     <= 32'h0;
			step_cnt_reg <= 32'h0;
			btn_prev_reg <= 1'b0;
			disp_on_reg  <= 1'b0;
			to_cnt_reg   <= 32'h0;
		end else begin
			mode_reg     <= mode_next;
			mode_o       <= mode_next;
			btn_prev_reg <= disp_btn_i;
			if (mode_reg == FPI_TEST && tick) begin
				step_cnt_reg <= step_end ? 32'h0 : step_cnt_reg + 32'h1;
				step_reg     <= step_end ? step_reg + 32'h1 : step_reg;
			end
			if (btn_rise) begin
				disp_on_reg <= !disp_on_reg;
				to_cnt_reg  <= 32'h0;
			end else if (to_hit) begin
				disp_on_reg <= 1'b0;
				to_cnt_reg  <= 32'h0;
			end else if (disp_on_reg && tick) begin
				to_cnt_reg <= to_cnt_reg + 32'h1;
			end
		end
	end

	// flicker and data-flash stretchers make short events visible
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync_prev_reg <= 1'b0;
			flick_cnt_reg <= 32'h0;
			for (int p = 0; p < 2; p++) begin
				din_cnt_reg[p]  <= 32'h0;
				dout_cnt_reg[p] <= 32'h0;
			end
		end else begin
			sync_prev_reg <= rx_sync_i;
			if (sync_drop) begin
				flick_cnt_reg <= `FPI_FLICK_MS;
			end else if (flick_on && tick) begin
				flick_cnt_reg <= flick_cnt_reg - 32'h1;
			end
			for (int p = 0; p < 2; p++) begin
				if (port_in_data_i[p]) begin
					din_cnt_reg[p] <= `FPI_DATA_MS;
				end else if (din_cnt_reg[p] != 32'h0 && tick) begin
					din_cnt_reg[p] <= din_cnt_reg[p] - 32'h1;
				end
				if (port_out_data_i[p]) begin
					dout_cnt_reg[p] <= `FPI_DATA_MS;
				end else if (dout_cnt_reg[p] != 32'h0 && tick) begin
					dout_cnt_reg[p] <= dout_cnt_reg[p] - 32'h1;
				end
			end
		end
	end

	// offset peak hold: a larger magnitude restarts the hold at once
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			peak_reg     <= 8'sh00;
			hold_cnt_reg <= 32'h0;
		end else if (peak_new || hold_end) begin
			peak_reg     <= freq_off_i;
			hold_cnt_reg <= 32'h0;
		end else if (tick) begin
			hold_cnt_reg <= hold_cnt_reg + 32'h1;
		end
	end

	// ****************************************************************
	// status lamps
	// ****************************************************************
	// hardware error overrides every status lamp so the fault cannot be missed
	wire hw = hw_error_i;
	wire pwr_r = hw ? blink_reg : tx_active_i;
	wire pwr_g = !hw && !tx_active_i && powerup_ok_i;
	wire rx_r  = hw ? blink_reg :
		rx_carrier_i && (!rx_sync_i || flick_on);
	wire rx_g  = !hw && rx_carrier_i && rx_sync_i && !flick_on;
	wire [1:0] din_on  = port_in_data_i | {din_cnt_reg[1] != 32'h0,
		din_cnt_reg[0] != 32'h0}; // pulse lights at once
	wire [1:0] dout_on = port_out_data_i | {dout_cnt_reg[1] != 32'h0,
		dout_cnt_reg[0] != 32'h0};
	wire [1:0] dat_r = hw ? {2{blink_reg}} : din_on;
	wire [1:0] dat_g = hw ? 2'h0 : dout_on;
	// ****************************************************************
	// meters
	// ****************************************************************
	wire integer sup = int'(supply_i);
	wire integer txp = int'(tx_power_i);
	wire integer drv = int'(tx_drive_i);
	wire integer rxs = int'(rx_sig_i);
	wire integer fov = (int'(peak_reg) > `FPI_FO_SPAN) ? `FPI_FO_SPAN :
		(int'(peak_reg) < -`FPI_FO_SPAN) ? -`FPI_FO_SPAN : int'(peak_reg);
	wire integer fo_idx = ((fov + `FPI_FO_SPAN) * (SEG - 1)) /
		(2 * `FPI_FO_SPAN);
	wire fo_bad = (mag(peak_reg) > `FPI_FO_LIM);
	wire [SEG-1:0] fo_seg = rx_carrier_i ? onehot(fo_idx) : '0;
	wire [SEG-1:0] sup_r = (sup < `FPI_SUP_OK) ?
		bar(sup, `FPI_SUP_LO, `FPI_SUP_OK) :
		(sup >= `FPI_SUP_HI) ? LAST : '0;
	wire [SEG-1:0] sup_g = (sup >= `FPI_SUP_HI) ? ~LAST :
		(sup >= `FPI_SUP_OK) ? ALL : '0;
	wire [SEG-1:0] txp_r = (txp >= `FPI_TXP_HI) ? LAST : '0;
	wire [SEG-1:0] txp_g = (txp >= `FPI_TXP_HI) ? ~LAST :
		bar(txp, `FPI_TXP_LO, `FPI_TXP_HI);
	wire [SEG-1:0] drv_r = (drv >= `FPI_DRV_HI) ? LAST : '0;
	wire [SEG-1:0] drv_g = (drv >= `FPI_DRV_HI) ? ~LAST :
		bar(drv, `FPI_DRV_LO, `FPI_DRV_HI);
	wire [SEG-1:0] rxs_r = (rxs < `FPI_RX_OK) ?
		bar(rxs, `FPI_RX_LO, `FPI_RX_OK) : '0;
	wire [SEG-1:0] rxs_g = (rxs >= `FPI_RX_OK) ?
		bar(rxs, `FPI_RX_OK, `FPI_RX_TOP) : '0;
	// lamp test walks one segment through all meters, red pass then green
	wire integer   step_i   = int'(step_reg);
	wire           test     = (mode_reg == FPI_TEST);
	wire           show     = (mode_reg == FPI_RUN) && disp_on_reg;
	wire [SEG-1:0] tp       = onehot(step_i % SEG);
	wire [SEG-1:0] tst_r    = (test && step_i < SEG) ? tp : '0;
	wire [SEG-1:0] tst_g    = (test && step_i >= SEG) ? tp : '0;
	wire [SEG-1:0] gate     = show ? ALL : '0;
	// every lamp output is a flop, so no decode glitch reaches a pin
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{power_tx_indicator_red_o, power_tx_indicator_green_o,
				rx_sync_red_o, rx_sync_green_o, data_red_o,
				data_green_o} <= 8'h00;
			{sup_red_o, sup_green_o, txp_red_o, txp_green_o, drv_red_o,
				drv_green_o, rxs_red_o, rxs_green_o, fo_red_o,
				fo_green_o} <= '0;
		end else begin
			{power_tx_indicator_red_o, power_tx_indicator_green_o,
				rx_sync_red_o, rx_sync_green_o, data_red_o,
				data_green_o} <= {pwr_r, pwr_g, rx_r, rx_g, dat_r, dat_g};
			sup_red_o   <= (sup_r & gate) | tst_r;
			sup_green_o <= (sup_g & gate) | tst_g;
			txp_red_o   <= (txp_r & gate) | tst_r;
			txp_green_o <= (txp_g & gate) | tst_g;
			drv_red_o   <= (drv_r & gate) | tst_r;
			drv_green_o <= (drv_g & gate) | tst_g;
			rxs_red_o   <= (rxs_r & gate) | tst_r;
			rxs_green_o <= (rxs_g & gate) | tst_g;
			fo_red_o    <= (fo_bad ? fo_seg & gate : '0) | tst_r;
			fo_green_o  <= (fo_bad ? '0 : fo_seg & gate) | tst_g;
		end
	end
	// ****************************************************************
	// checks
	// ****************************************************************
	a_pwr_tx_red: assert property (tx_active_i && !hw_error_i |=>
		power_tx_indicator_red_o && !power_tx_indicator_green_o)
		else $error("power lamp not red while transmitting");
	a_hw_err_flash: assert property (hw_error_i |=>
		rx_sync_red_o == $past(blink_reg) && !rx_sync_green_o &&
		data_green_o == 2'h0)
		else $error("hardware error flash wrong");
	a_rx_dark: assert property (!rx_carrier_i && !hw_error_i |=>
		!rx_sync_red_o && !rx_sync_green_o)
		else $error("receive lamp lit without signal");
	a_sync_flicker: assert property (sync_drop && !hw_error_i ##1
		(rx_carrier_i && !hw_error_i)[*4] |=> rx_sync_red_o)
		else $error("sync loss flicker too short");
	a_data_flash: assert property (port_in_data_i[0] && !hw_error_i |=>
		data_red_o[0])
		else $error("port data flash missing");
	a_btn_toggle: assert property (btn_rise |=>
		disp_on_reg != $past(disp_on_reg))
		else $error("display did not toggle");
	a_disp_timeout: assert property (to_hit && !btn_rise |=>
		!disp_on_reg ##1 sup_green_o == '0 || test)
		else $error("display timeout failed");
	a_sup_low: assert property (show && sup < `FPI_SUP_LO |=>
		sup_red_o == '0 && sup_green_o == '0)
		else $error("supply meter lit below threshold");
	a_txp_top: assert property (show && txp >= `FPI_TXP_HI |=>
		txp_red_o == LAST && txp_green_o == ~LAST)
		else $error("power meter top wrong");
	a_rx_green: assert property (show && rxs >= `FPI_RX_OK |=>
		rxs_red_o == '0 && rxs_green_o[0])
		else $error("receive meter green missing");
	a_fo_dark: assert property (show && !rx_carrier_i |=>
		fo_red_o == '0 && fo_green_o == '0)
		else $error("offset meter lit without signal");
	a_peak_hold: assert property (!peak_new && !hold_end |=>
		peak_reg == $past(peak_reg))
		else $error("peak released early");
	a_test_walk: assert property (test |=>
		$onehot(sup_red_o | sup_green_o) && fo_green_o == sup_green_o)
		else $error("lamp test pattern wrong");
	c_test: cover property (mode_reg == FPI_TEST ##1 mode_reg == FPI_RUN);
	c_hw: cover property (hw_error_i && $rose(blink_reg));
	c_hold: cover property (hold_end && !peak_new);
	c_timeout: cover property (to_hit);
endmodule
`default_nettype wire

// *** shared/fpi_defs.svh ***
// timing counts, thresholds and sizes of the front-panel indicator block
`ifndef FPI_DEFS_SVH
`define FPI_DEFS_SVH
// ****************************************************************
// sizes and timing
// ****************************************************************
`define FPI_SEG         10
`define FPI_CLK_NS      20
`define FPI_MS_NS       1000000
`define FPI_TICK_CYC    (`FPI_MS_NS / `FPI_CLK_NS)
`define FPI_FLASH_HZ    1
`define FPI_BLINK_MS    (1000 / (2 * `FPI_FLASH_HZ))
`define FPI_DISP_TO_MIN 5
`define FPI_DISP_TO_MS  (`FPI_DISP_TO_MIN * 60000)
`define FPI_PEAK_S      5
`define FPI_PEAK_MS     (`FPI_PEAK_S * 1000)
`define FPI_FLICK_MS    100
`define FPI_DATA_MS     50
`define FPI_TEST_MS     100
// ****************************************************************
// meter thresholds (supply 0.1 V, power 0.1 dBm, offset 0.1 kHz)
// ****************************************************************
`define FPI_SUP_LO      100
`define FPI_SUP_OK      110
`define FPI_SUP_HI      157
`define FPI_TXP_LO      200
`define FPI_TXP_HI      407
`define FPI_DRV_LO      100
`define FPI_DRV_HI      260
`define FPI_RX_LO       (-1200)
`define FPI_RX_OK       (-1100)
`define FPI_RX_TOP      (-600)
`define FPI_FO_LIM      36
`define FPI_FO_SPAN     50
`endif

// *** shared/fpi_pkg.sv ***
// types of the front-panel indicator block
`default_nettype none
package fpi_pkg;
	// operating mode: capture strap, lamp test, normal running
	typedef enum logic [1:0] {FPI_INIT, FPI_TEST, FPI_RUN} fpi_mode_t;
endpackage
`default_nettype wire

// *** verification/fpi_panel.sv ***
// operator push button model standing in front of the indicator block
`default_nettype none
module fpi_panel (
	input  wire logic ref_clk_i,
	input  wire logic hold_i,
	input  wire logic press_i,
	output logic      btn_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// button contact
	// ************************************************************
	int unsigned down_cnt = 0;
	// a tap keeps the contact closed a few cycles, like a real finger
	always @(posedge ref_clk_i) begin
		down_cnt <= press_i ? 3 : (down_cnt != 0 ? down_cnt - 1 : 0);
	end
	// held across power-up asks for the lamp
	assign btn_o = hold_i | press_i | (down_cnt != 0);
endmodule
`default_nettype wire

// *** verification/fpi_ctrl_bench.sv ***
// self-checking bench of the front-panel indicator controller
`include "fpi_defs.svh"
`default_nettype none
module fpi_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import fpi_pkg::*;
	// ************************************************************
	// set-up, shortened counts keep the run short
	// ************************************************************
	localparam int SEG = `FPI_SEG;
	localparam int TK  = 4;   // cycles per tick
	localparam int DTO = 200; // display on-time in ticks
	localparam int PK  = 10;  // peak hold in ticks
	typedef logic [SEG-1:0] fpi_seg_t;
	localparam fpi_seg_t LAST = fpi_seg_t'(1) << (SEG - 1);
	logic ref_clk_i, arst_n_i, powerup_ok_i, tx_active_i, hw_error_i;
	logic rx_carrier_i, rx_sync_i, disp_btn_i, hold, press, r;
	logic [1:0] port_in_data_i, port_out_data_i, data_red_o, data_green_o;
	logic [7:0] supply_i;
	logic [8:0] tx_power_i, tx_drive_i;
	logic signed [11:0] rx_sig_i;
	logic signed [7:0]  freq_off_i;
	fpi_mode_t mode_o;
	logic power_tx_indicator_red_o, power_tx_indicator_green_o;
	logic rx_sync_red_o, rx_sync_green_o;
	fpi_seg_t sup_red_o, sup_green_o, txp_red_o, txp_green_o;
	fpi_seg_t drv_red_o, drv_green_o, rxs_red_o, rxs_green_o;
	fpi_seg_t fo_red_o, fo_green_o;
	int q_sel[$];
	fpi_seg_t q_val[$];
	int err_total = 0;
	int checks_done = 0;
	event chk_ev;

	fpi_ctrl #(.SEG(SEG), .TICK_CYC(TK), .DISP_TO_MS(DTO), .PEAK_MS(PK))
	i_dut (
		.ref_clk_i, .arst_n_i, .powerup_ok_i, .tx_active_i, .hw_error_i,
		.rx_carrier_i, .rx_sync_i, .port_in_data_i, .port_out_data_i,
		.disp_btn_i, .supply_i, .tx_power_i, .tx_drive_i, .rx_sig_i,
		.freq_off_i, .mode_o, .power_tx_indicator_red_o,
		.power_tx_indicator_green_o, .rx_sync_red_o, .rx_sync_green_o,
		.data_red_o, .data_green_o, .sup_red_o, .sup_green_o, .txp_red_o,
		.txp_green_o, .drv_red_o, .drv_green_o, .rxs_red_o, .rxs_green_o,
		.fo_red_o, .fo_green_o
	);
	fpi_panel i_panel (
		.ref_clk_i, .hold_i(hold), .press_i(press), .btn_o(disp_btn_i)
	);

	// clock at 50 MHz
	initial begin
		ref_clk_i = 1'b0;
		forever #(`FPI_CLK_NS / 2) ref_clk_i = ~ref_clk_i;
	end

	// ************************************************************
	// helpers and scoreboard
	// ************************************************************
	// selector 10 packs the status lamps, 11 the mode
	function automatic fpi_seg_t obs(input int s);
		fpi_seg_t m[12];
		m = '{sup_red_o, sup_green_o, txp_red_o, txp_green_o, drv_red_o,
			drv_green_o, rxs_red_o, rxs_green_o, fo_red_o, fo_green_o,
			fpi_seg_t'({power_tx_indicator_red_o, power_tx_indicator_green_o,
			rx_sync_red_o, rx_sync_green_o, data_red_o, data_green_o}),
			fpi_seg_t'(mode_o)};
		return m[s];
	endfunction
	function automatic fpi_seg_t bar(input int v, input int lo, input int hi);
		int n;
		n = v < lo ? 0 : (v >= hi ? SEG : (v - lo) * SEG / (hi - lo) + 1);
		return n >= SEG ? '1 : fpi_seg_t'((1 << n) - 1);
	endfunction
	task automatic note(input int s, input fpi_seg_t v);
		q_sel.push_back(s);
		q_val.push_back(v);
		-> chk_ev;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task automatic press_btn();
		press = 1'b1;
		cyc(1);
		press = 1'b0;
		cyc(6);
	endtask
	// watcher compares once the drive edge has settled
	initial forever begin
		@(chk_ev);
		#1;
		while (q_sel.size() > 0) begin
			checks_done++;
			if (obs(q_sel[0]) !== q_val[0]) begin
				err_total++;
				$display("[ERR] %0t sel %0d got %h exp %h", $time, q_sel[0],
					obs(q_sel[0]), q_val[0]);
			end
			void'(q_sel.pop_front());
			void'(q_val.pop_front());
		end
	end
	task automatic meters(input int s, input int p, input int d, input int v);
		supply_i = s[7:0];
		tx_power_i = p[8:0];
		tx_drive_i = d[8:0];
		rx_sig_i = v[11:0];
		cyc(3);
		note(0, (s >= 100 && s < 110) ? bar(s, 100, 110) :
			(s >= 157 ? LAST : '0));
		note(1, s < 110 ? '0 : (s >= 157 ? ~LAST : '1));
		note(2, p >= 407 ? LAST : '0);
		note(3, p >= 407 ? ~LAST : bar(p, 200, 407));
		note(4, d >= 260 ? LAST : '0);
		note(5, d >= 260 ? ~LAST : bar(d, 100, 260));
		note(6, v < -1100 ? bar(v, -1200, -1100) : '0);
		note(7, v >= -1100 ? bar(v, -1100, -600) : '0);
		note(9, fpi_seg_t'(1) << 4);
	endtask
	task automatic fo_chk(input int o, input int w, input logic red,
		input int i);
		freq_off_i = o[7:0];
		cyc(w);
		note(8, red ? fpi_seg_t'(1) << i : '0);
		note(9, red ? '0 : fpi_seg_t'(1) << i);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// watchdog well beyond the expected run of about 12000 cycles
	initial begin
		#(40000 * `FPI_CLK_NS);
		err_total++;
		summarize();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{arst_n_i, powerup_ok_i, tx_active_i, hw_error_i} = 4'h0;
		{rx_carrier_i, rx_sync_i, press} = 3'h0;
		{port_in_data_i, port_out_data_i} = 4'h0;
		{supply_i, tx_power_i, tx_drive_i} = 26'h0;
		rx_sig_i = 12'h000;
		freq_off_i = 8'h00;
		hold = 1'b1;
		void'($urandom(38165));
		cyc(6);
		arst_n_i = 1'b1;
		cyc(3);
		note(11, fpi_seg_t'(FPI_TEST));
		note(0, fpi_seg_t'(8'h01));
		hold = 1'b0;
		cyc(SEG * 100 * TK + 100);
		note(1, fpi_seg_t'(8'h01));
		cyc(SEG * 100 * TK);
		note(11, fpi_seg_t'(FPI_RUN));
		note(10, fpi_seg_t'(8'h00));
		powerup_ok_i = 1'b1;
		cyc(3);
		note(10, fpi_seg_t'(8'h40));
		tx_active_i = 1'b1;
		cyc(3);
		note(10, fpi_seg_t'(8'h80));
		tx_active_i = 1'b0;
		rx_carrier_i = 1'b1;
		cyc(3);
		note(10, fpi_seg_t'(8'h60));
		rx_sync_i = 1'b1;
		cyc(3);
		note(10, fpi_seg_t'(8'h50));
		// a one-cycle sync drop must still give a visible flicker
		rx_sync_i = 1'b0;
		cyc(1);
		rx_sync_i = 1'b1;
		cyc(5);
		note(10, fpi_seg_t'(8'h60));
		cyc(100 * TK + 20);
		note(10, fpi_seg_t'(8'h50));
		port_in_data_i = 2'h1;
		port_out_data_i = 2'h2;
		cyc(1);
		{port_in_data_i, port_out_data_i} = 4'h0;
		cyc(5);
		note(10, fpi_seg_t'(8'h56));
		cyc(50 * TK + 20);
		note(10, fpi_seg_t'(8'h50));
		supply_i = 8'h82;
		note(1, '0);
		press_btn();
		note(1, '1);
		press_btn();
		note(1, '0);
		press_btn();
		// boundary values first, then random ones
		meters(100, 200, 100, -1200);
		meters(109, 406, 259, -1101);
		meters(157, 407, 260, -1100);
		meters(99, 199, 99, -1201);
		repeat (16) meters($urandom_range(170, 90), $urandom_range(420, 190),
			$urandom_range(270, 90), $urandom_range(800) - 1300);
		fo_chk(36, 3, 1'b0, 7);
		fo_chk(37, 3, 1'b1, 7);
		fo_chk(-50, 3, 1'b1, 0);
		fo_chk(0, 5, 1'b1, 0);
		fo_chk(0, PK * TK + 20, 1'b0, 4);
		rx_carrier_i = 1'b0;
		supply_i = 8'h82;
		cyc(3);
		note(9, '0);
		note(10, fpi_seg_t'(8'h40));
		note(1, '1);
		cyc(DTO * TK);
		note(1, '0);
		hw_error_i = 1'b1;
		cyc(3);
		r = power_tx_indicator_red_o;
		note(10, fpi_seg_t'({r, 1'b0, r, 1'b0, r, r, 2'h0}));
		cyc(500 * TK);
		note(10, fpi_seg_t'({~r, 1'b0, ~r, 1'b0, ~r, ~r, 2'h0}));
		cyc(2);
		// a second reset without the button held must come up running
		hw_error_i = 1'b0;
		arst_n_i = 1'b0;
		cyc(2);
		note(11, fpi_seg_t'(FPI_INIT));
		note(10, fpi_seg_t'(8'h00));
		arst_n_i = 1'b1;
		cyc(3);
		note(11, fpi_seg_t'(FPI_RUN));
		note(10, fpi_seg_t'(8'h40));
		note(1, '0);
		cyc(1);
		summarize();
	end
endmodule
`default_nettype wire
